// *** bench/event_source.sv ***
// Purpose: far-side pad model feeding every capture source
// Assumes: one level per unit, routing known
// Notes: unused sources show the inverse level
`timescale 1ns/1ps
`default_nettype none
module event_source (
  // routing
  input wire logic [3:0] level_in,
  input wire logic [3:0] alt_sel_in,
  input wire logic [3:0] dir_in,
  // pads
  output logic [3:0] pin_out,
  output logic [3:0] alt_pin_out,
  output logic [3:0] port_level_out
);
  // a wrong route then sees the opposite edge
  assign pin_out = ~(level_in ^ (dir_in & ~alt_sel_in));
  assign alt_pin_out = ~(level_in ^ (dir_in & alt_sel_in));
  assign port_level_out = ~(level_in ^ ~dir_in);
endmodule // event_source
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the capture unit
// Assumes: capture lands within 4 cycles
// Notes: timebase held still while an edge settles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import capture_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] tb = 16'h0000;
  logic [15:0] seed = 16'h0035;
  logic [15:0] mode = 16'h0000;
  logic [3:0] lvl = 4'h0, alt = 4'h0, dir = 4'hF, clr = 4'h0, en = 4'h0;
  logic [3:0] pin, apin, port, flag, irq, e_flag;
  logic [31:0] vh, vl, e_vh, e_vl;
  int cnt[4];
  int bad_count = 0, samples_checked = 0, cycles = 0;
  event_source event_source_i (.level_in(lvl), .alt_sel_in(alt),
    .dir_in(dir), .pin_out(pin), .alt_pin_out(apin),
    .port_level_out(port));
  timer_capture_unit timer_capture_unit_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .timebase_count_high_in(tb[15:8]),
    .timebase_count_low_in(tb[7:0]), .capture_input_pin_in(pin),
    .capture_alt_pin_in(apin), .pin_direction_in(dir),
    .port_out_level_in(port), .alt_pin_select_in(alt),
    .capture_mode_select_in(mode), .capture_flag_clear_in(clr),
    .capture_int_enable_in(en), .capture_flag_out(flag),
    .capture_irq_out(irq), .capture_value_high_out(vh),
    .capture_value_low_out(vl));
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic results();
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      bad_count++;
      $display("unexpected at %0t: want %h got %h", $time, e, g);
    end
  endtask
  task automatic check_all();
    chk({28'h0, e_flag}, {28'h0, flag});
    chk({28'h0, e_flag & en}, {28'h0, irq});
    chk(e_vh, vh);
    chk(e_vl, vl);
  endtask
  // timebase moves only here, synchronous to the bench clock
  task automatic edge_all(input logic [3:0] nl);
    logic [3:0] m;
    logic fire;
    @(negedge clk_in);
    seed = lfsr(seed);
    tb = seed;
    for (int i = 0; i < 4; i++) begin
      m = mode[4*i +: 4];
      fire = 1'b0;
      if (nl[i] != lvl[i]) begin
        if (m == MODE_FALL) fire = !nl[i];
        if (m == MODE_RISE) fire = nl[i];
        if (nl[i] && (m == MODE_RISE4 || m == MODE_RISE16)) begin
          fire = cnt[i] >= (m == MODE_RISE4 ? 3 : 15);
          cnt[i] = fire ? 0 : cnt[i] + 1;
        end
      end
      if (fire) begin
        e_flag[i] = 1'b1;
        e_vh[8*i +: 8] = tb[15:8];
        e_vl[8*i +: 8] = tb[7:0];
      end
    end
    lvl = nl;
    repeat (6) @(negedge clk_in);
    check_all();
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      edge_all(4'hF);
      edge_all(4'h0);
    end
  endtask
  task automatic set_mode(input logic [15:0] nm);
    @(negedge clk_in);
    for (int i = 0; i < 4; i++)
      if (!(nm[4*i +: 4] inside {[4:7]})) cnt[i] = 0;
    mode = nm;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic clear_flags();
    @(negedge clk_in);
    clr = 4'hF;
    @(negedge clk_in);
    clr = 4'h0;
    e_flag = 4'h0;
    @(negedge clk_in);
    check_all();
  endtask
  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    e_flag = 4'h0;
    e_vh = 32'h0;
    e_vl = 32'h0;
    for (int i = 0; i < 4; i++) cnt[i] = 0;
    check_all();
  endtask
  initial begin
    logic [15:0] nm;
    do_reset();
    for (int k = 0; k < 4; k++) begin
      set_mode(16'h0000);
      seed = lfsr(seed);
      {en, dir, alt} = seed[11:0];
      clear_flags();
      for (int i = 0; i < 4; i++) nm[4*i +: 4] = 4'(4 + (i + k) % 4);
      set_mode(nm);
      pulses(17);
    end
    set_mode(16'h0000);
    clear_flags();
    set_mode(16'h7777);
    pulses(5);
    set_mode(16'h6666);
    pulses(1);
    set_mode(16'h7777);
    pulses(5);
    do_reset();
    pulses(16);
    results();
  end
endmodule // testbench
`default_nettype wire

// *** logic/capture_pkg.sv ***
// Purpose: shared constants for the capture unit
// Assumes: 4-bit mode field, 16-bit timebase
// Notes: mode codes follow the usual capture encodings
`default_nettype none
package capture_pkg;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_FALL = 4'h4;
  localparam logic [3:0] MODE_RISE = 4'h5;
  localparam logic [3:0] MODE_RISE4 = 4'h6;
  localparam logic [3:0] MODE_RISE16 = 4'h7;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [3:0] PRESCALE_LAST4 = 4'h3;
  localparam logic [3:0] PRESCALE_LAST16 = 4'hF;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam int UNITS = 4;
  localparam int PIN_CHOICES = 2;
endpackage
`default_nettype wire

// *** logic/edge_prescaler.sv ***
// Purpose: edge selection and event prescaling for one capture unit
// Assumes: level already synchronised
// Notes: prescaler is kept across prescale changes by design
`timescale 1ns/1ps
`default_nettype none
module edge_prescaler (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic [3:0] mode_in,
  input wire logic level_in,
  // event
  output logic fire_out
);
  import capture_pkg::*;
  typedef struct packed {
    logic last;
    logic [3:0] count;
    logic fire;
  } ep_state_t;
  ep_state_t st, next_st;
  logic rise, fall, capmode;
  always_comb begin
    next_st = st;
    rise = level_in & ~st.last;
    fall = ~level_in & st.last;
    capmode = (mode_in == MODE_FALL) || (mode_in == MODE_RISE) ||
              (mode_in == MODE_RISE4) || (mode_in == MODE_RISE16);
    next_st.last = level_in;
    next_st.fire = 1'b0;
    if (!capmode) begin
      next_st.count = PRESCALE_RESET; // [RQ5]
    end else if (mode_in == MODE_FALL) begin
      next_st.fire = fall; // [RQ2]
    end else if (mode_in == MODE_RISE) begin
      next_st.fire = rise; // [RQ2]
    end else if (rise) begin
      // count carries over a direct prescale change [RQ7]
      if ((mode_in == MODE_RISE4 && st.count >= PRESCALE_LAST4) ||
          (mode_in == MODE_RISE16 && st.count == PRESCALE_LAST16)) begin
        next_st.fire = 1'b1; // [RQ16]
        next_st.count = PRESCALE_RESET; // [RQ16]
      end else begin
        next_st.count = st.count + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0; // [RQ6]
    end else begin
      st <= next_st;
    end
  end
  assign fire_out = st.fire;

  a_prescale_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !capmode |=> st.count == PRESCALE_RESET) // [RQ5]
    else $error("prescaler not held at zero");
  a_rise_fire: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == MODE_RISE && level_in && !st.last) |=> fire_out) // [RQ2]
    else $error("rising edge missed");
  a_fall_fire: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == MODE_FALL && !level_in && st.last) |=> fire_out) // [RQ2]
    else $error("falling edge missed");
  a_div_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == MODE_RISE16 && rise && st.count == PRESCALE_LAST16)
    |=> fire_out && st.count == PRESCALE_RESET) // [RQ16]
    else $error("divide by sixteen wrap wrong");
  a_fire_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fire_out |-> $past(capmode)) // [RQ5]
    else $error("event outside capture mode");
  c_div4: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_in == MODE_RISE4 && fire_out);
  c_div16: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_in == MODE_RISE16 && fire_out);
endmodule // edge_prescaler
`default_nettype wire

// *** logic/pin_sync.sv ***
// Purpose: two-stage synchroniser for one pin level
// Assumes: pin is asynchronous to clk_in
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // level
  input wire logic pin_in,
  output logic level_out
);
  logic meta;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta <= pin_in;
      level_out <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** logic/timer_capture_unit.sv ***
// Purpose: four-instance input capture of a 16-bit timebase
// Assumes: timebase counts on clk_in, pins are asynchronous
// Notes: flag clear input is a pulse per unit; set wins over clear
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RQ1) On a capture event the full 16-bit timebase count is stored.
// (RQ2) The mode field selects falling, rising, every 4th or 16th rise.
// (RQ3) Each capture sets the flag, which only software clears.
// (RQ4) A newer capture overwrites an unread stored value.
// (RQ5) The prescaler is held at zero when off or not in capture mode.
// (RQ6) Any reset clears the prescaler counter.
// (RQ7) A direct prescale change keeps the count and may fire falsely.
// (RQ8) Software should switch the unit off before a new prescale.
// (RQ9) Mode changes may cause false flags; software keeps enable clear.
// (RQ10) The timebase must run synchronously for capture to work.
// (RQ11) The timebase must not be clocked from the undivided clock.
// (RQ12) A pin driven as output still reaches the edge detector.
// (RQ13) Software should set the pin as input in capture mode.
// (RQ14) The capture input may be taken from an alternate pin.
// (RQ15) All four instances behave alike with their own state.
// (RQ16) Divided modes fire at the count, then restart from zero.
module timer_capture_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // timebase
  input wire logic [7:0] timebase_count_high_in,
  input wire logic [7:0] timebase_count_low_in,
  // pins, default and alternate per unit
  input wire logic [3:0] capture_input_pin_in,
  input wire logic [3:0] capture_alt_pin_in,
  input wire logic [3:0] pin_direction_in,
  input wire logic [3:0] port_out_level_in,
  // control
  input wire logic [3:0] alt_pin_select_in,
  input wire logic [15:0] capture_mode_select_in,
  input wire logic [3:0] capture_flag_clear_in,
  input wire logic [3:0] capture_int_enable_in,
  // status
  output logic [3:0] capture_flag_out,
  output logic [3:0] capture_irq_out,
  output logic [31:0] capture_value_high_out,
  output logic [31:0] capture_value_low_out
);
  import capture_pkg::*;
  typedef struct packed {
    logic [3:0] flag;
    logic [3:0] irq;
    logic [31:0] high;
    logic [31:0] low;
  } cap_state_t;
  cap_state_t st, next_st;
  logic [3:0] fire;
  logic [3:0] level;
  logic [3:0] pad;

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit // [RQ15]
      // pad reads the driven level when output, so a port write can
      // trigger a capture [RQ12]; alternate pin routing [RQ14]
      assign pad[g] = !pin_direction_in[g] ? port_out_level_in[g] :
        (alt_pin_select_in[g] ? capture_alt_pin_in[g] :
         capture_input_pin_in[g]);
      pin_sync u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(pad[g]),
        .level_out(level[g])
      );
      edge_prescaler u_pre (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mode_in(capture_mode_select_in[4*g +: 4]),
        .level_in(level[g]),
        .fire_out(fire[g])
      );
    end
  endgenerate

  always_comb begin
    next_st = st;
    for (int i = 0; i < UNITS; i++) begin
      if (fire[i]) begin
        // no guard for unread data, newest wins [RQ4]
        next_st.high[8*i +: 8] = timebase_count_high_in; // [RQ1]
        next_st.low[8*i +: 8] = timebase_count_low_in; // [RQ1]
        next_st.flag[i] = 1'b1; // [RQ3]
      end else if (capture_flag_clear_in[i]) begin
        next_st.flag[i] = 1'b0; // [RQ3]
      end
      // gated by enable so software can mask false flags [RQ9]
      next_st.irq[i] = next_st.flag[i] & capture_int_enable_in[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign capture_flag_out = st.flag;
  assign capture_irq_out = st.irq;
  assign capture_value_high_out = st.high;
  assign capture_value_low_out = st.low;

  a_capture_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fire[0] |=> capture_value_low_out[7:0] == $past(timebase_count_low_in) &&
      capture_value_high_out[7:0] == $past(timebase_count_high_in)) // [RQ1]
    else $error("capture value not stored");
  a_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fire[0] |=> capture_flag_out[0]) // [RQ3]
    else $error("flag not set on capture");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    capture_flag_out[1] && !capture_flag_clear_in[1] |=>
      capture_flag_out[1]) // [RQ3]
    else $error("flag cleared by hardware");
  a_value_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !fire[2] |=> $stable(capture_value_low_out[23:16])) // [RQ4]
    else $error("value changed without capture");
  c_capture: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    fire[0] ##1 capture_irq_out[0]);
  c_overwrite: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    fire[3] && capture_flag_out[3]);
endmodule // timer_capture_unit
`default_nettype wire
